/* File: src/eis_pkg.sv */
// Purpose: Shared types and constants for the extended instruction execution subset.
// Assumes: One 10 MHz system instruction clock and a synchronous active-low core reset.
// Notes: Program memory is 2K words of 16 bits and table pointers are one byte each.
//
// Notes on behaviour
// RL1 - skip_nonzero_ext skips the next instruction when the byte is nonzero; no flags.
// RL2 - Every taken conditional skip lasts two cycles, the second being an inserted dummy.
// RL3 - sub_ext writes working_register minus the byte back into working_register.
// RL4 - sub_to_mem_ext writes the difference to the byte and leaves working_register.
// RL5 - After subtraction borrow_out_bit is 0 when negative, 1 when zero or positive.
// RL6 - Both subtractions update all six status flags.
// RL7 - nibble_swap_ext swaps the nibbles of the byte in place, flags untouched.
// RL8 - nibble_swap_acc_ext puts the swapped byte into working_register only; no flags.
// RL9 - skip_zero_ext skips the next instruction when the byte is zero; no flags.
// RL10 - skip_zero_copy_ext copies the byte to working_register, skips if zero; no flags.
// RL11 - The bit-test skip skips when the selected bit is 0; no flags.
// RL12 - table_read_cur_ext reads the current page at table_pointer_low, low and high bytes.
// RL13 - table_read_last_ext reads the last page at table_pointer_low, low and high bytes.
// RL14 - table_read_inc_ext bumps table_pointer_low, then reads at both pointers.
// RL15 - table_read_inc_last_ext bumps table_pointer_low, then reads the last page.
// RL16 - xor_ext puts working_register XOR byte into working_register; only result_nil_flag.
// RL17 - xor_to_mem_ext puts the XOR into the byte; only result_nil_flag changes.
// RL18 - The dummy cycle discards the fetched instruction with no side effects.
// RL19 - A false skip condition finishes in one cycle and the next instruction runs.

package eis_pkg;

    localparam int PROG_AW   = 11;
    localparam int PAGE_W    = 3;
    localparam int BYTE_W    = 8;
    localparam int NIB_W     = 4;
    localparam int WORD_W    = 16;

    localparam logic [PAGE_W-1:0] LAST_PAGE = 3'h7;
    localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [BYTE_W-1:0] PTR_STEP  = 8'h01;

    // Instruction codes handed over by the fetch pipeline.
    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_SKIP_NZ   = 4'h1,
        OP_SUB       = 4'h2,
        OP_SUB_MEM   = 4'h3,
        OP_SWAP      = 4'h4,
        OP_SWAP_ACC  = 4'h5,
        OP_SKIP_Z    = 4'h6,
        OP_SKIP_ZCP  = 4'h7,
        OP_SKIP_BIT  = 4'h8,
        OP_TRD_CUR   = 4'h9,
        OP_TRD_LAST  = 4'hA,
        OP_TRD_INC   = 4'hB,
        OP_TRD_INCL  = 4'hC,
        OP_XOR       = 4'hD,
        OP_XOR_MEM   = 4'hE
    } eis_op_type;

    typedef enum logic {
        ST_EXEC  = 1'b0,
        ST_DUMMY = 1'b1
    } eis_state_type;

    // Status flags; the same layout serves as a write mask.
    typedef struct packed {
        logic signed_range_exceeded;
        logic result_nil_flag;
        logic nibble_borrow_bit;
        logic borrow_out_bit;
        logic signed_result_flag;
        logic chained_nil_flag;
    } eis_flags_type;

    localparam eis_flags_type FLAGS_NONE = 6'h00;
    localparam eis_flags_type FLAGS_ALL  = 6'h3F;
    localparam eis_flags_type FLAGS_ZERO = 6'h10;

    typedef struct packed {
        logic       valid;
        eis_op_type op;
        logic [2:0] bit_sel;
    } eis_instr_type;

    // Write-back bundle towards register file, data memory and table latch.
    typedef struct packed {
        logic                wreg_we;
        logic [BYTE_W-1:0]   wreg;
        logic                mem_we;
        logic [BYTE_W-1:0]   mem;
        eis_flags_type       flag_we;
        eis_flags_type       flags;
        logic                table_high_latch_we;
        logic [BYTE_W-1:0]   table_high_latch;
        logic                table_pointer_low_we;
        logic [BYTE_W-1:0]   table_pointer_low;
    } eis_result_type;

    localparam eis_result_type RESULT_IDLE = '0;

endpackage

/* File: src/eis_sub_alu.sv */
// Purpose: Eight-bit subtraction with the full set of status flags.
// Assumes: Purely combinational; operands are stable within the cycle.
// Notes: Borrow flags are inverted borrows, so 1 means no borrow occurred.
`timescale 1ns/1ps
`default_nettype none

module eis_sub_alu (
    // Operands
    input  wire logic [7:0]          minuend,
    input  wire logic [7:0]          subtrahend,
    // Result
    output logic [7:0]               difference,
    output eis_pkg::eis_flags_type   flags
);

    logic [8:0] wide;
    logic [4:0] low;

    // One extra bit catches the borrow out of each stage.
    always_comb begin
        wide       = {1'b0, minuend} - {1'b0, subtrahend};
        low        = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
        difference = wide[7:0];
        flags.signed_range_exceeded = (minuend[7] != subtrahend[7]) && (wide[7] != minuend[7]);
        flags.result_nil_flag       = (wide[7:0] == eis_pkg::ZERO_BYTE);
        flags.nibble_borrow_bit     = ~low[4];
        flags.borrow_out_bit        = ~wide[8];
        flags.signed_result_flag    = flags.signed_range_exceeded ^ wide[7];
        // Without a carry-in there is no earlier result to chain, so it follows zero.
        flags.chained_nil_flag      = flags.result_nil_flag;
    end

endmodule // eis_sub_alu

`default_nettype wire

/* File: src/eis_exec.sv */
// Purpose: Executes the skip, subtract, swap, table read and XOR extended instructions.
// Assumes: Operand byte, working register and program word arrive in the issue cycle.
// Notes: Write-backs are registered and appear one cycle after the instruction is taken.
`timescale 1ns/1ps
`default_nettype none

module eis_exec (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    // Instruction from the fetch pipeline
    input  wire eis_pkg::eis_instr_type  instr,
    // Operands
    input  wire logic [7:0]              wreg_in,
    input  wire logic [7:0]              mem_rdata,
    // Table pointers and program memory
    input  wire logic [7:0]              table_pointer_low_in,
    input  wire logic [7:0]              table_pointer_high_in,
    input  wire logic [2:0]              cur_page,
    output logic [10:0]                  prog_addr,
    input  wire logic [15:0]             prog_rdata,
    // Write-back and sequencing
    output eis_pkg::eis_result_type      result,
    output logic                         skip_taken,
    output logic                         dummy_cycle
);

    eis_pkg::eis_state_type  state;
    eis_pkg::eis_state_type  next_state;
    eis_pkg::eis_result_type next_result;
    logic                    next_skip;
    logic [7:0]              sub_diff;
    eis_pkg::eis_flags_type  sub_flags;
    logic [7:0]              swapped;
    logic [7:0]              xor_val;
    logic [7:0]              table_pointer_low_inc;
    logic                    go;

    ////////////////////////////////////////////////////////////////////////////
    // Datapath helpers

    eis_sub_alu u_sub (
        .minuend    (wreg_in),
        .subtrahend (mem_rdata),
        .difference (sub_diff),
        .flags      (sub_flags)
    );

    // Shared operand transforms for the swap, xor and pointer-bump forms.
    assign swapped  = {mem_rdata[eis_pkg::NIB_W-1:0], mem_rdata[eis_pkg::BYTE_W-1:eis_pkg::NIB_W]};
    assign xor_val  = wreg_in ^ mem_rdata;
    assign table_pointer_low_inc = table_pointer_low_in + eis_pkg::PTR_STEP;
    assign go       = instr.valid && (state == eis_pkg::ST_EXEC);

    // Program address is combinational so the word returns in the issue cycle.
    always_comb begin
        case (instr.op)
            eis_pkg::OP_TRD_LAST: prog_addr = {eis_pkg::LAST_PAGE, table_pointer_low_in};   // [RL13]
            eis_pkg::OP_TRD_INC:  prog_addr = {table_pointer_high_in[2:0], table_pointer_low_inc};        // [RL14]
            eis_pkg::OP_TRD_INCL: prog_addr = {eis_pkg::LAST_PAGE, table_pointer_low_inc};  // [RL15]
            default:              prog_addr = {cur_page, table_pointer_low_in};             // [RL12]
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Execute decode

    // The dummy state ignores whatever the pipeline presents, so no write leaks out.
    always_comb begin
        next_result = eis_pkg::RESULT_IDLE;
        next_skip   = 1'b0;
        next_state  = eis_pkg::ST_EXEC;
        if (go) begin
            case (instr.op)
                eis_pkg::OP_SKIP_NZ: begin
                    next_skip = (mem_rdata != eis_pkg::ZERO_BYTE);               // [RL1]
                end
                eis_pkg::OP_SUB: begin
                    next_result.wreg_we = 1'b1;                                  // [RL3]
                    next_result.wreg    = sub_diff;
                    next_result.flag_we = eis_pkg::FLAGS_ALL;                    // [RL6]
                    next_result.flags   = sub_flags;                             // [RL5]
                end
                eis_pkg::OP_SUB_MEM: begin
                    next_result.mem_we  = 1'b1;                                  // [RL4]
                    next_result.mem     = sub_diff;
                    next_result.flag_we = eis_pkg::FLAGS_ALL;                    // [RL6]
                    next_result.flags   = sub_flags;                             // [RL5]
                end
                eis_pkg::OP_SWAP: begin
                    next_result.mem_we = 1'b1;                                   // [RL7]
                    next_result.mem    = swapped;
                end
                eis_pkg::OP_SWAP_ACC: begin
                    next_result.wreg_we = 1'b1;                                  // [RL8]
                    next_result.wreg    = swapped;
                end
                eis_pkg::OP_SKIP_Z: begin
                    next_skip = (mem_rdata == eis_pkg::ZERO_BYTE);               // [RL9]
                end
                eis_pkg::OP_SKIP_ZCP: begin
                    next_result.wreg_we = 1'b1;                                  // [RL10]
                    next_result.wreg    = mem_rdata;
                    next_skip           = (mem_rdata == eis_pkg::ZERO_BYTE);
                end
                eis_pkg::OP_SKIP_BIT: begin
                    next_skip = ~mem_rdata[instr.bit_sel];                       // [RL11]
                end
                eis_pkg::OP_TRD_CUR, eis_pkg::OP_TRD_LAST: begin
                    next_result.mem_we  = 1'b1;                                  // [RL12] [RL13]
                    next_result.mem     = prog_rdata[eis_pkg::BYTE_W-1:0];
                    next_result.table_high_latch_we = 1'b1;
                    next_result.table_high_latch    = prog_rdata[eis_pkg::WORD_W-1:eis_pkg::BYTE_W];
                end
                eis_pkg::OP_TRD_INC, eis_pkg::OP_TRD_INCL: begin
                    next_result.table_pointer_low_we = 1'b1;                                  // [RL14] [RL15]
                    next_result.table_pointer_low    = table_pointer_low_inc;
                    next_result.mem_we  = 1'b1;
                    next_result.mem     = prog_rdata[eis_pkg::BYTE_W-1:0];
                    next_result.table_high_latch_we = 1'b1;
                    next_result.table_high_latch    = prog_rdata[eis_pkg::WORD_W-1:eis_pkg::BYTE_W];
                end
                eis_pkg::OP_XOR: begin
                    next_result.wreg_we = 1'b1;                                  // [RL16]
                    next_result.wreg    = xor_val;
                    next_result.flag_we = eis_pkg::FLAGS_ZERO;
                    next_result.flags.result_nil_flag = (xor_val == eis_pkg::ZERO_BYTE);
                end
                eis_pkg::OP_XOR_MEM: begin
                    next_result.mem_we  = 1'b1;                                  // [RL17]
                    next_result.mem     = xor_val;
                    next_result.flag_we = eis_pkg::FLAGS_ZERO;
                    next_result.flags.result_nil_flag = (xor_val == eis_pkg::ZERO_BYTE);
                end
                default: begin
                    next_skip = 1'b0;
                end
            endcase
        end
        // A taken skip buys exactly one dummy cycle; a false one stays single-cycle.
        if (next_skip) begin
            next_state = eis_pkg::ST_DUMMY;                                      // [RL2] [RL19]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers

    // Everything the outside sees except prog_addr is registered to keep memory write timing clean.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state      <= eis_pkg::ST_EXEC;
            result     <= eis_pkg::RESULT_IDLE;
            skip_taken <= 1'b0;
        end else begin
            state      <= next_state;
            result     <= next_result;                                           // [RL18]
            skip_taken <= next_skip;
        end
    end

    assign dummy_cycle = (state == eis_pkg::ST_DUMMY);

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic op_is_sub;
    assign op_is_sub = go && (instr.op == eis_pkg::OP_SUB || instr.op == eis_pkg::OP_SUB_MEM);

    property p_skip_nz;
        go && instr.op == eis_pkg::OP_SKIP_NZ |=>
            dummy_cycle == ($past(mem_rdata) != 8'h00) && result.flag_we == eis_pkg::FLAGS_NONE;
    endproperty
    a_skip_nz: assert property (p_skip_nz) else $error("Nonzero skip mismatch."); // [RL1]

    property p_two_cycle;
        skip_taken |-> dummy_cycle ##1 !dummy_cycle && !skip_taken;
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("Skip not two cycles."); // [RL2]

    property p_sub;
        go && instr.op == eis_pkg::OP_SUB |=>
            result.wreg_we && !result.mem_we && result.wreg == 8'($past(wreg_in) - $past(mem_rdata));
    endproperty
    a_sub: assert property (p_sub) else $error("Subtract result wrong."); // [RL3]

    property p_sub_mem;
        go && instr.op == eis_pkg::OP_SUB_MEM |=>
            result.mem_we && !result.wreg_we && result.mem == 8'($past(wreg_in) - $past(mem_rdata));
    endproperty
    a_sub_mem: assert property (p_sub_mem) else $error("Subtract to memory wrong."); // [RL4]

    property p_borrow;
        op_is_sub |=> result.flags.borrow_out_bit == ($past(wreg_in) >= $past(mem_rdata));
    endproperty
    a_borrow: assert property (p_borrow) else $error("Borrow flag wrong."); // [RL5]

    property p_six_flags;
        op_is_sub |=> result.flag_we == eis_pkg::FLAGS_ALL
            && result.flags.result_nil_flag == ($past(wreg_in) == $past(mem_rdata));
    endproperty
    a_six_flags: assert property (p_six_flags) else $error("Subtract flags not all updated."); // [RL6]

    property p_swap;
        go && instr.op == eis_pkg::OP_SWAP |=> result.mem_we && result.flag_we == eis_pkg::FLAGS_NONE
            && result.mem == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("Nibble swap wrong."); // [RL7]

    property p_skip_z;
        go && instr.op == eis_pkg::OP_SKIP_Z |=> dummy_cycle == ($past(mem_rdata) == 8'h00);
    endproperty
    a_skip_z: assert property (p_skip_z) else $error("Zero skip mismatch."); // [RL9]

    property p_inc_addr;
        go && instr.op == eis_pkg::OP_TRD_INC |-> prog_addr == {table_pointer_high_in[2:0], 8'(table_pointer_low_in + 8'h01)}
            ##1 result.table_pointer_low_we && result.table_high_latch_we && result.mem_we;
    endproperty
    a_inc_addr: assert property (p_inc_addr) else $error("Incrementing table read wrong."); // [RL14]

    property p_xor;
        go && instr.op == eis_pkg::OP_XOR |=> result.flag_we == eis_pkg::FLAGS_ZERO
            && result.wreg == ($past(wreg_in) ^ $past(mem_rdata));
    endproperty
    a_xor: assert property (p_xor) else $error("XOR result or flags wrong."); // [RL16]

    property p_dummy_quiet;
        dummy_cycle |=> result == eis_pkg::RESULT_IDLE && !skip_taken;
    endproperty
    a_dummy_quiet: assert property (p_dummy_quiet) else $error("Dummy cycle had side effects."); // [RL18]

    property p_no_skip;
        go && instr.op == eis_pkg::OP_SKIP_BIT && mem_rdata[instr.bit_sel] |=> !dummy_cycle && !skip_taken;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("False skip stalled."); // [RL19]

    c_sub_neg:   cover property (op_is_sub && wreg_in < mem_rdata);
    c_skip_tk:   cover property (skip_taken ##1 instr.valid);
    c_table_inc: cover property (go && instr.op == eis_pkg::OP_TRD_INCL && table_pointer_low_in == 8'hFF);

endmodule // eis_exec

`default_nettype wire

/* File: test/eis_prog_mem_model.sv */
// Purpose: Program memory model on the far side of the executor's table port.
// Assumes: Asynchronous read, because the executor expects the word in the issue cycle.
// Notes: Contents follow a fixed address pattern, so the bench can predict every word.
`timescale 1ns/1ps
`default_nettype none

module eis_prog_mem_model (
    // Address from the executor
    input  wire logic [10:0] prog_addr,
    // Word back to the executor
    output logic      [15:0] prog_rdata
);
    // Every address holds a distinct word, so a wrong page or pointer shows up as a wrong byte.
    always_comb begin
        prog_rdata = {prog_addr[7:0] ^ 8'h5A, prog_addr[10:8], prog_addr[4:0] ^ 5'h13};
    end
endmodule // eis_prog_mem_model
`default_nettype wire

/* File: test/extended_instr_exec_subset_tb.sv */
// Purpose: Self-checking bench for the extended instruction executor.
// Assumes: Inputs change 1 ns after the rising edge; results appear one cycle after issue.
// Notes: Data fields whose write enable is low are masked, since they carry no meaning.
`timescale 1ns/1ps
`default_nettype none

module extended_instr_exec_subset_tb;
    logic                    sys_clk     = 1'b0;
    logic                    rst_n       = 1'b0;
    eis_pkg::eis_instr_type  instr       = '0;
    logic [7:0]              wreg_in     = 8'h00;
    logic [7:0]              mem_rdata   = 8'h00;
    logic [7:0]              table_pointer_low_in     = 8'h00;
    logic [7:0]              table_pointer_high_in     = 8'h00;
    logic [2:0]              cur_page    = 3'h0;
    logic [10:0]             prog_addr;
    logic [15:0]             prog_rdata;
    eis_pkg::eis_result_type result;
    logic                    skip_taken;
    logic                    dummy_cycle;
    int                      mismatches  = 0;
    int                      check_count = 0;
    logic [31:0]             rng         = 32'h0000_0053;
    eis_pkg::eis_result_type pend_res    = '0;
    logic                    pend_skip   = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // The clock toggles every half period of 50 ns.
    always #50 sys_clk = ~sys_clk;

    eis_exec eis_exec_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .instr(instr), .wreg_in(wreg_in), .mem_rdata(mem_rdata),
        .table_pointer_low_in(table_pointer_low_in), .table_pointer_high_in(table_pointer_high_in), .cur_page(cur_page), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata), .result(result), .skip_taken(skip_taken), .dummy_cycle(dummy_cycle)
    );

    eis_prog_mem_model eis_prog_mem_model_i (.prog_addr(prog_addr), .prog_rdata(prog_rdata));

    ////////////////////////////////////////////////////////////////////////////
    // Helpers that predict the executor's answer.
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    function automatic logic [15:0] word_at(input logic [10:0] a);
        return {a[7:0] ^ 8'h5A, a[10:8], a[4:0] ^ 5'h13};
    endfunction

    function automatic eis_pkg::eis_result_type visible(input eis_pkg::eis_result_type r);
        eis_pkg::eis_result_type v;
        v = r;
        v.wreg = r.wreg_we ? r.wreg : 8'h00;
        v.mem = r.mem_we ? r.mem : 8'h00;
        v.table_high_latch = r.table_high_latch_we ? r.table_high_latch : 8'h00;
        v.table_pointer_low = r.table_pointer_low_we ? r.table_pointer_low : 8'h00;
        v.flags = eis_pkg::eis_flags_type'(r.flags & r.flag_we);
        return v;
    endfunction

    function automatic eis_pkg::eis_result_type predict(input eis_pkg::eis_instr_type i,
            input logic [7:0] w, input logic [7:0] m, input logic [7:0] tp, input logic [7:0] th,
            input logic [2:0] pg, output logic sk, output logic [10:0] pa);
        eis_pkg::eis_result_type r;
        logic [7:0]              d;
        logic [15:0]             pw;
        r = '0;
        sk = 1'b0;
        pa = 11'h000;
        d = w - m;
        case (i.op)
            eis_pkg::OP_SKIP_NZ: sk = (m != 8'h00);
            eis_pkg::OP_SKIP_Z: sk = (m == 8'h00);
            eis_pkg::OP_SKIP_BIT: sk = ~m[i.bit_sel];
            eis_pkg::OP_SKIP_ZCP: begin
                sk = (m == 8'h00);
                r.wreg_we = 1'b1;
                r.wreg = m;
            end
            eis_pkg::OP_SUB, eis_pkg::OP_SUB_MEM: begin
                r.flag_we = eis_pkg::FLAGS_ALL;
                r.flags.borrow_out_bit = (w >= m);
                r.flags.nibble_borrow_bit = (w[3:0] >= m[3:0]);
                r.flags.result_nil_flag = (d == 8'h00);
                r.flags.chained_nil_flag = (d == 8'h00);
                r.flags.signed_range_exceeded = (w[7] != m[7]) && (d[7] != w[7]);
                r.flags.signed_result_flag = r.flags.signed_range_exceeded ^ d[7];
                r.wreg_we = (i.op == eis_pkg::OP_SUB);
                r.wreg = d;
                r.mem_we = (i.op == eis_pkg::OP_SUB_MEM);
                r.mem = d;
            end
            eis_pkg::OP_SWAP: begin
                r.mem_we = 1'b1;
                r.mem = {m[3:0], m[7:4]};
            end
            eis_pkg::OP_SWAP_ACC: begin
                r.wreg_we = 1'b1;
                r.wreg = {m[3:0], m[7:4]};
            end
            eis_pkg::OP_XOR, eis_pkg::OP_XOR_MEM: begin
                r.flag_we = eis_pkg::FLAGS_ZERO;
                r.flags.result_nil_flag = ((w ^ m) == 8'h00);
                r.wreg_we = (i.op == eis_pkg::OP_XOR);
                r.mem_we = (i.op == eis_pkg::OP_XOR_MEM);
                r.wreg = w ^ m;
                r.mem = w ^ m;
            end
            eis_pkg::OP_TRD_CUR, eis_pkg::OP_TRD_LAST, eis_pkg::OP_TRD_INC, eis_pkg::OP_TRD_INCL: begin
                r.table_pointer_low_we = (i.op == eis_pkg::OP_TRD_INC) || (i.op == eis_pkg::OP_TRD_INCL);
                r.table_pointer_low = tp + 8'h01;
                pa[7:0] = r.table_pointer_low_we ? r.table_pointer_low : tp;
                pa[10:8] = (i.op == eis_pkg::OP_TRD_CUR) ? pg : 3'h7;
                pa[10:8] = (i.op == eis_pkg::OP_TRD_INC) ? th[2:0] : pa[10:8];
                pw = word_at(pa);
                r.mem_we = 1'b1;
                r.mem = pw[7:0];
                r.table_high_latch_we = 1'b1;
                r.table_high_latch = pw[15:8];
            end
            default: ;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Comparison and closing report.
    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One cycle: check the previous issue, drive a new one and predict its answer.
    task automatic step(input logic rs, input logic v, input eis_pkg::eis_op_type op, input logic [2:0] bs,
            input logic [7:0] w, input logic [7:0] m, input logic [7:0] tp, input logic [7:0] th,
            input logic [2:0] pg);
        eis_pkg::eis_result_type r;
        logic                    sk;
        logic [10:0]             pa;
        @(posedge sys_clk);
        #1;
        check("result", visible(result), visible(pend_res));
        check("skip_taken", 48'(skip_taken), 48'(pend_skip));
        check("dummy_cycle", 48'(dummy_cycle), 48'(pend_skip));
        rst_n = rs;
        instr = {v, op, bs};
        wreg_in = w;
        mem_rdata = m;
        table_pointer_low_in = tp;
        table_pointer_high_in = th;
        cur_page = pg;
        r = predict(instr, w, m, tp, th, pg, sk, pa);
        #1;
        if (v && op >= eis_pkg::OP_TRD_CUR && op <= eis_pkg::OP_TRD_INCL) begin
            check("prog_addr", 48'(prog_addr), 48'(pa));
        end
        // A request during the dummy cycle is discarded, so nothing is expected from it.
        if (!rs || pend_skip || !v) begin
            r = '0;
            sk = 1'b0;
        end
        pend_res = r;
        pend_skip = sk;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog so that a stuck run still reaches the verdict.
    initial begin
        #2_000_000;
        mismatches++;
        finish_test();
    end

    // Reset, corner cases, then random traffic with a reset in mid-run.
    initial begin
        for (int k = 0; k < 6; k++) begin
            step(1'b0, 1'b1, eis_pkg::OP_SUB, 3'h0, 8'h12, 8'h34, 8'h00, 8'h00, 3'h0);
        end
        step(1'b1, 1'b1, eis_pkg::OP_SKIP_Z, 3'h0, 8'h11, 8'h00, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b1, eis_pkg::OP_SUB_MEM, 3'h0, 8'h40, 8'h01, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b1, eis_pkg::OP_SUB, 3'h0, 8'h00, 8'h01, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b1, eis_pkg::OP_SUB, 3'h0, 8'h80, 8'h01, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b1, eis_pkg::OP_SUB_MEM, 3'h0, 8'h5A, 8'h5A, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b1, eis_pkg::OP_SKIP_NZ, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b1, eis_pkg::OP_SWAP, 3'h0, 8'h00, 8'hC3, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b1, eis_pkg::OP_SKIP_NZ, 3'h0, 8'h00, 8'h01, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b1, eis_pkg::OP_SKIP_Z, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b1, eis_pkg::OP_SKIP_ZCP, 3'h0, 8'h77, 8'h00, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b1, eis_pkg::OP_XOR_MEM, 3'h0, 8'h0F, 8'hF0, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b1, eis_pkg::OP_SWAP_ACC, 3'h0, 8'h00, 8'h96, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b1, eis_pkg::OP_TRD_INC, 3'h0, 8'h00, 8'h00, 8'hFF, 8'h05, 3'h2);
        step(1'b1, 1'b1, eis_pkg::OP_TRD_INCL, 3'h0, 8'h00, 8'h00, 8'hFF, 8'h05, 3'h2);
        step(1'b1, 1'b1, eis_pkg::OP_XOR, 3'h0, 8'h3C, 8'h3C, 8'h00, 8'h00, 3'h0);
        for (int b = 0; b < 8; b++) begin
            step(1'b1, 1'b1, eis_pkg::OP_SKIP_BIT, 3'(b), 8'h00, 8'hA5, 8'h00, 8'h00, 3'h0);
        end
        for (int k = 0; k < 3000; k++) begin
            rng = xorshift(rng);
            step(!(k >= 1500 && k < 1502), rng[31:30] != 2'h0, eis_pkg::eis_op_type'(rng[3:0]), rng[6:4],
                 rng[15:8], (rng[19:17] == 3'h0) ? 8'h00 : rng[27:20], rng[23:16], rng[29:22], rng[9:7]);
        end
        step(1'b1, 1'b0, eis_pkg::OP_NONE, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0);
        step(1'b1, 1'b0, eis_pkg::OP_NONE, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0);
        finish_test();
    end
endmodule // extended_instr_exec_subset_tb
`default_nettype wire
